//--- core/pdr_pkg.sv
// Package for the packet DMA pointer register block.
// Assumes an 8-bit register port and one core clock.
`default_nettype none
package pdr_pkg;
  localparam int unsigned REG_AW = 4;
  localparam logic [3:0] OFS_TX_PAGE = 4'h0;
  localparam logic [3:0] OFS_TX_LEN_LO = 4'h1;
  localparam logic [3:0] OFS_TX_LEN_HI = 4'h2;
  localparam logic [3:0] OFS_RING_FIRST = 4'h3;
  localparam logic [3:0] OFS_RING_LAST = 4'h4;
  localparam logic [3:0] OFS_RING_GUARD = 4'h5;
  localparam logic [3:0] OFS_RESUME = 4'h6;
  localparam logic [3:0] OFS_LDMA_LO = 4'h7;
  localparam logic [3:0] OFS_LDMA_HI = 4'h8;
  localparam logic [3:0] OFS_RBEGIN_LO = 4'h9;
  localparam logic [3:0] OFS_RBEGIN_HI = 4'hA;
  localparam logic [3:0] OFS_RLEN_LO = 4'hB;
  localparam logic [3:0] OFS_RLEN_HI = 4'hC;
  localparam logic [3:0] OFS_STATUS = 4'hD;
  localparam logic [3:0] OFS_TX_LEFT_LO = 4'hE;
  localparam logic [3:0] OFS_TX_LEFT_HI = 4'hF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [7:0] PAGE_ONE = 8'h01;
  // Status bit positions
  localparam int unsigned ST_TX_BUSY = 0;
  localparam int unsigned ST_RX_BUSY = 1;
  localparam int unsigned ST_RX_ABORT = 2;
  localparam int unsigned ST_RM_BUSY = 3;
  typedef enum logic [1:0] {
    PDR_IDLE,
    PDR_TX,
    PDR_RX
  } pdr_local_e;
endpackage
`default_nettype wire

//--- core/pdr_fifo.sv
// Small synchronous FIFO placed in the transmit data path.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module pdr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } pdr_fifo_s;
  pdr_fifo_s st;
  pdr_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign o_in_ready = (st.cnt != (PW+1)'(DEPTH));
  assign o_out_valid = (st.cnt != '0);
  assign o_out_data = mem[st.rd];
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && i_out_ready && o_out_valid;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = (st.wr == PW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == PW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage carries no reset; only pointers and count need a defined value
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[st.wr] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

//--- core/pdr_top.sv
// Pointer and count registers for the local and remote DMA channels.
// Assumes an 8-bit register port, a packet memory that answers each
// request in the cycle it is taken, and pins already synchronised.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pdr_top
  import pdr_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [REG_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_tx_start,
  output logic o_tx_done,
  output logic [15:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  input wire logic [7:0] i_mem_rdata,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [7:0] o_tx_data,
  input wire logic i_rx_begin,
  input wire logic i_rx_page_full,
  input wire logic i_rx_good,
  input wire logic i_rx_error,
  output logic o_rx_abort,
  input wire logic i_rm_step,
  input wire logic i_rm_word,
  output logic [15:0] o_rm_addr,
  output logic o_rm_done
);
  typedef struct packed {
    pdr_local_e mode;
    logic [7:0] tx_page;
    logic [15:0] tx_len;
    logic [15:0] tx_left;
    logic [7:0] ring_first;
    logic [7:0] ring_last;
    logic [7:0] ring_guard;
    logic [7:0] resume;
    logic [15:0] ldma;
    logic [15:0] rm_addr;
    logic [15:0] rm_len;
    logic rx_abort;
    logic tx_done;
    logic rm_done;
    logic [7:0] rdata;
  } pdr_top_s;

  pdr_top_s st;
  pdr_top_s next_st;
  logic fifo_ready;
  logic fetch;
  logic [7:0] status;
  logic [7:0] next_page;
  logic [15:0] rm_step;
  logic [7:0] rd_mux;

  // Fetch only while the FIFO has room, so a stalled sink stalls memory
  assign fetch = i_ce && (st.mode == PDR_TX) && (st.tx_left != WORD_ZERO)
    && fifo_ready;
  // Wrap back to the first page on reaching the last page, which is never used
  assign next_page = (st.ldma[15:8] + PAGE_ONE == st.ring_last) ?
    st.ring_first : st.ldma[15:8] + PAGE_ONE;
  assign rm_step = i_rm_word ? STEP_WORD : STEP_BYTE;

  // Status bits placed by name so the map lives in the package only
  always_comb begin
    status = BYTE_ZERO;
    status[ST_TX_BUSY] = (st.mode == PDR_TX);
    status[ST_RX_BUSY] = (st.mode == PDR_RX);
    status[ST_RX_ABORT] = st.rx_abort;
    status[ST_RM_BUSY] = (st.rm_len != WORD_ZERO);
  end

  assign o_mem_addr = st.ldma;
  assign o_mem_rd = fetch;
  assign o_mem_wr = i_ce && (st.mode == PDR_RX) && !st.rx_abort;
  assign o_rdata = st.rdata;
  assign o_rx_abort = st.rx_abort;
  assign o_tx_done = st.tx_done;
  assign o_rm_done = st.rm_done;
  assign o_rm_addr = st.rm_addr;

  // Read multiplexer, every register one byte wide
  always_comb begin
    rd_mux = BYTE_ZERO;
    case (i_addr)
      OFS_TX_PAGE: rd_mux = st.tx_page;
      OFS_TX_LEN_LO: rd_mux = st.tx_len[7:0];
      OFS_TX_LEN_HI: rd_mux = st.tx_len[15:8];
      OFS_RING_FIRST: rd_mux = st.ring_first;
      OFS_RING_LAST: rd_mux = st.ring_last;
      OFS_RING_GUARD: rd_mux = st.ring_guard;
      OFS_RESUME: rd_mux = st.resume;
      OFS_LDMA_LO: rd_mux = st.ldma[7:0];
      OFS_LDMA_HI: rd_mux = st.ldma[15:8];
      OFS_RBEGIN_LO: rd_mux = st.rm_addr[7:0];
      OFS_RBEGIN_HI: rd_mux = st.rm_addr[15:8];
      OFS_RLEN_LO: rd_mux = st.rm_len[7:0];
      OFS_RLEN_HI: rd_mux = st.rm_len[15:8];
      OFS_STATUS: rd_mux = status;
      OFS_TX_LEFT_LO: rd_mux = st.tx_left[7:0];
      OFS_TX_LEFT_HI: rd_mux = st.tx_left[15:8];
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  // Whole next-state computation
  always_comb begin
    next_st = st;
    next_st.tx_done = 1'b0;
    next_st.rm_done = 1'b0;
    if (i_rd) begin
      next_st.rdata = rd_mux;
    end
    if (i_wr) begin
      case (i_addr)
        OFS_TX_PAGE: next_st.tx_page = i_wdata;
        OFS_TX_LEN_LO: next_st.tx_len[7:0] = i_wdata;
        OFS_TX_LEN_HI: next_st.tx_len[15:8] = i_wdata;
        OFS_RING_FIRST: next_st.ring_first = i_wdata;
        OFS_RING_LAST: next_st.ring_last = i_wdata;
        OFS_RING_GUARD: next_st.ring_guard = i_wdata;
        OFS_RESUME: next_st.resume = i_wdata;
        OFS_RBEGIN_LO: next_st.rm_addr[7:0] = i_wdata;
        OFS_RBEGIN_HI: next_st.rm_addr[15:8] = i_wdata;
        OFS_RLEN_LO: next_st.rm_len[7:0] = i_wdata;
        OFS_RLEN_HI: next_st.rm_len[15:8] = i_wdata;
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    // Remote channel steps; a count of one with a word step ends at zero
    if (i_rm_step && st.rm_len != WORD_ZERO) begin
      next_st.rm_addr = st.rm_addr + rm_step;
      if (st.rm_len <= rm_step) begin
        next_st.rm_len = WORD_ZERO;
        next_st.rm_done = 1'b1;
      end else begin
        next_st.rm_len = st.rm_len - rm_step;
      end
    end
    // Local channel sequencing
    case (st.mode)
      PDR_IDLE: begin
        if (i_tx_start) begin
          next_st.mode = PDR_TX;
          next_st.ldma = {st.tx_page, BYTE_ZERO};
          next_st.tx_left = st.tx_len;
        end else if (i_rx_begin) begin
          next_st.mode = PDR_RX;
          next_st.rx_abort = 1'b0;
          next_st.ldma = {st.resume, BYTE_ZERO};
        end
      end
      PDR_TX: begin
        // Counts to zero with no length cap at all
        if (st.tx_left == WORD_ZERO) begin
          next_st.mode = PDR_IDLE;
          next_st.tx_done = 1'b1;
        end else if (fetch) begin
          next_st.ldma = st.ldma + STEP_BYTE;
          next_st.tx_left = st.tx_left - STEP_BYTE;
        end
      end
      PDR_RX: begin
        if (i_rx_error) begin
          next_st.ldma = {st.resume, BYTE_ZERO};
          next_st.mode = PDR_IDLE;
        end else if (i_rx_good) begin
          // Next frame starts on the page after this one
          next_st.resume = next_page;
          next_st.mode = PDR_IDLE;
        end else if (i_rx_page_full && !st.rx_abort) begin
          if (next_page == st.ring_guard) begin
            // Abort ends the receive, so the next begin can clear the flag
            next_st.rx_abort = 1'b1;
            next_st.mode = PDR_IDLE;
          end else begin
            next_st.ldma = {next_page, BYTE_ZERO};
          end
        end else if (o_mem_wr) begin
          next_st.ldma[7:0] = st.ldma[7:0] + PAGE_ONE;
        end
      end
      default: next_st.mode = PDR_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // Byte FIFO between packet memory and the transmit serialiser
  pdr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_in_valid(fetch),
    .o_in_ready(fifo_ready),
    .i_in_data(i_mem_rdata),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_data)
  );
endmodule
`default_nettype wire

//--- test/pdr_mem_model.sv
// Packet buffer memory seen by the local DMA fetch port.
// Assumes fetches are answered in the cycle they are made.
`timescale 1ns/100ps
`default_nettype none
module pdr_mem_model (
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  // Frames sit at page starts; byte is a mix of the address halves
  // Idle bus shows the inverse so stale data never looks right
  assign o_rdata = i_rd ? i_addr[7:0] ^ i_addr[15:8]
    : ~(i_addr[7:0] ^ i_addr[15:8]);
endmodule
`default_nettype wire

//--- test/pdr_props.sv
// Port checker for the pointer register block.
// Assumes sends and remote steps come only when they will be taken.
`timescale 1ns/100ps
`default_nettype none
module pdr_props
  import pdr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [REG_AW-1:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] o_rdata,
  input wire logic i_tx_start,
  input wire logic o_tx_done,
  input wire logic [15:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic i_rx_begin,
  input wire logic i_rx_page_full,
  input wire logic i_rx_good,
  input wire logic i_rx_error,
  input wire logic o_rx_abort,
  input wire logic i_rm_step,
  input wire logic i_rm_word,
  input wire logic [15:0] o_rm_addr
);
  // Single domain, all checks off while in reset
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  a_tx_low: assert property (i_ce && i_tx_start |=>
    o_mem_addr[7:0] == 8'h00) else $error("send start off page");
  a_fetch_step: assert property (i_ce && o_mem_rd |=>
    o_mem_addr == $past(o_mem_addr) + 16'h0001) else $error("fetch step");
  a_fill_step: assert property (i_ce && o_mem_wr &&
    !(i_rx_page_full || i_rx_error || i_rx_good) |=>
    o_mem_addr == {$past(o_mem_addr[15:8]),
    8'($past(o_mem_addr[7:0]) + 8'h01)}) else $error("receive step");
  a_abort_hold: assert property (o_rx_abort && !i_rx_begin |=>
    o_rx_abort) else $error("abort dropped");
  a_abort_quiet: assert property (o_rx_abort |-> !o_mem_wr)
    else $error("write after abort");
  a_rm_byte: assert property (i_ce && i_rm_step && !i_rm_word |=>
    o_rm_addr == $past(o_rm_addr) + 16'h0001) else $error("byte step");
  a_rm_word: assert property (i_ce && i_rm_step && i_rm_word |=>
    o_rm_addr == $past(o_rm_addr) + 16'h0002) else $error("word step");
  a_rm_still: assert property (!i_rm_step && !i_wr |=>
    $stable(o_rm_addr)) else $error("remote address moved");
  a_ldma_high: assert property (i_ce && i_rd &&
    i_addr == OFS_LDMA_HI |=> o_rdata == 8'($past(o_mem_addr) >> 8))
    else $error("local addr high");
  a_ldma_low: assert property (i_ce && i_rd &&
    i_addr == OFS_LDMA_LO |=> o_rdata == 8'($past(o_mem_addr)))
    else $error("local addr low");
  c_send_done: cover property (o_tx_done);
  c_abort: cover property (o_rx_abort);
  c_word: cover property (i_rm_step && i_rm_word);
endmodule
bind pdr_top pdr_props u_props (.i_core_clk, .i_resetn, .i_ce, .i_addr,
  .i_rd, .i_wr, .o_rdata, .i_tx_start, .o_tx_done, .o_mem_addr, .o_mem_rd,
  .o_mem_wr, .i_rx_begin, .i_rx_page_full, .i_rx_good, .i_rx_error,
  .o_rx_abort, .i_rm_step, .i_rm_word, .o_rm_addr);
`default_nettype wire

//--- test/tb.sv
// Random and corner-case bench for the pointer register block.
// Assumes a one-cycle register port and a same-cycle memory model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb;
  import pdr_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, rdy = 0, rmw = 0, ce = 1;
  logic w, done, mrd, mwr, txv, abt, rmd;
  logic [3:0] adr = 4'h0;
  logic [5:0] ev = 6'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat, mdat, txd, pg, b;
  logic [15:0] maddr, rma, a, cnt;
  logic [15:0] len = 16'h05DE;
  logic [3:0] wofs [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9,
    4'hA, 4'hB, 4'hC};
  logic [7:0] ring [4] = '{8'h40, 8'h43, 8'h3F, 8'h40};
  logic [7:0] pgs [3] = '{8'h41, 8'h42, 8'h40};
  int seed = 40182, num_errors = 0, n_compared = 0, got = 0;
  always #12.5 clk = ~clk;
  pdr_mem_model mem (.i_addr(maddr), .i_rd(mrd), .o_rdata(mdat));
  pdr_top dut (.i_core_clk(clk), .i_resetn(rstn), .i_ce(ce),
    .i_addr(adr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_tx_start(ev[0]), .o_tx_done(done), .o_mem_addr(maddr),
    .o_mem_rd(mrd), .o_mem_wr(mwr), .i_mem_rdata(mdat),
    .o_tx_valid(txv), .i_tx_ready(rdy), .o_tx_data(txd),
    .i_rx_begin(ev[1]), .i_rx_page_full(ev[2]), .i_rx_good(ev[5]),
    .i_rx_error(ev[3]), .o_rx_abort(abt), .i_rm_step(ev[4]),
    .i_rm_word(rmw), .o_rm_addr(rma), .o_rm_done(rmd));
  function automatic logic [7:0] exp_byte(input logic [15:0] x);
    return x[7:0] ^ x[15:8];
  endfunction
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    adr <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
    adr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
    @(posedge clk);
  endtask
  // One-cycle event pulse, returns just after the edge that took it
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
    #1;
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Sink stalls at random so the fetch FIFO fills and drains
  always @(posedge clk) begin
    if (txv && rdy) begin
      `CHK("tx byte", exp_byte({pg, 8'h00} + 16'(got)), txd)
      got++;
    end
    rdy <= 1'($random(seed));
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd_reg(4'(i), b);
      `CHK("reset value", 8'h00, b)
    end
    foreach (wofs[i]) begin
      a = 16'($random(seed));
      wr_reg(wofs[i], a[7:0]);
      rd_reg(wofs[i], b);
      `CHK("readback", a[7:0], b)
    end
    // Local address is read only
    wr_reg(OFS_LDMA_HI, 8'hA5);
    rd_reg(OFS_LDMA_HI, b);
    `CHK("local addr", 8'h00, b)
    // Low byte near the top so steps carry into the high byte
    a = {8'($random(seed)), 8'hFE};
    wr_reg(OFS_RBEGIN_LO, a[7:0]);
    wr_reg(OFS_RBEGIN_HI, a[15:8]);
    `CHK("remote start", a, rma)
    cnt = 16'h0107;
    wr_reg(OFS_RLEN_LO, cnt[7:0]);
    wr_reg(OFS_RLEN_HI, cnt[15:8]);
    while (cnt != 16'h0000) begin
      w = cnt > 16'h0001 ? 1'($random(seed)) : 1'b0;
      rmw <= w;
      pulse(4);
      a = a + (w ? 16'h0002 : 16'h0001);
      cnt = cnt - (w ? 16'h0002 : 16'h0001);
      `CHK("remote addr", a, rma)
      `CHK("remote done", cnt == 16'h0000, rmd)
      rd_reg(OFS_RLEN_LO, b);
      `CHK("remote count", cnt[7:0], b)
    end
    // Long frame must go out whole
    pg = 8'($random(seed));
    wr_reg(OFS_TX_PAGE, pg);
    wr_reg(OFS_TX_LEN_LO, len[7:0]);
    wr_reg(OFS_TX_LEN_HI, len[15:8]);
    pulse(0);
    `CHK("tx start", {pg, 8'h00}, maddr)
    rd_reg(OFS_STATUS, b);
    `CHK("tx status", 8'(1 << ST_TX_BUSY), b)
    for (int k = 0; k < 8000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("tx done", 1'b1, done)
    repeat (60) @(posedge clk);
    `CHK("tx count", len, 16'(got))
    // Ring 40..42, guard outside; resume equals first page
    foreach (ring[i]) wr_reg(4'(i + 3), ring[i]);
    pulse(1);
    pulse(2);
    pulse(3);
    `CHK("rx restore", 16'h4000, maddr)
    pulse(1);
    foreach (pgs[i]) begin
      pulse(2);
      `CHK("rx page", pgs[i], maddr[15:8])
    end
    wr_reg(OFS_RING_GUARD, 8'h41);
    pulse(2);
    `CHK("rx abort", 1'b1, abt)
    rd_reg(OFS_STATUS, b);
    `CHK("abort status", 8'(1 << ST_RX_ABORT), b)
    pulse(1);
    `CHK("abort clear", 1'b0, abt)
    // Good frame moves the resume page on; an error then restores it
    pulse(5);
    rd_reg(OFS_RESUME, b);
    `CHK("rx resume", 8'h41, b)
    pulse(1);
    pulse(2);
    pulse(3);
    `CHK("rx restore 2", 16'h4100, maddr)
    // Writes while the clock enable is low must not land
    ce <= 1'b0;
    wr_reg(OFS_TX_PAGE, ~pg);
    ce <= 1'b1;
    rd_reg(OFS_TX_PAGE, b);
    `CHK("ce freeze", pg, b)
    print_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
